// *** verilog/ttpo_pkg.sv ***
// Register map, reset values and carriers of the timed parallel output block
package ttpo_pkg;
   // Word index of each register, byte address is four times the index
   localparam logic [2:0] IDX_LOW_BUF = 3'h0;
   localparam logic [2:0] IDX_HIGH_BUF = 3'h1;
   localparam logic [2:0] IDX_MODE = 3'h2;
   localparam logic [2:0] IDX_CTRL = 3'h3;
   localparam logic [2:0] IDX_STATUS = 3'h4;
   localparam int IDX_LSB = 2;
   // Control field sits in bits 7:4 as {oe, edge_rise, six_bit, trig_sel}
   localparam int CTRL_FIELD_POS = 4;
   // High buffer bits sit above the four low bits in a buffer word
   localparam int HIGH_POS = 4;
   localparam int STATUS_PEND_POS = 6;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam logic [5:0] MODE_RESET = 6'h00;
   localparam logic [1:0] HIGH_RESET = 2'h0;
   localparam logic [3:0] LOW_RESET = 4'h0;
   localparam int FIFO_DEPTH_DEF = 8;

   typedef struct packed {
      logic chan_output_enable;
      logic trigger_edge_select;
      logic six_bit_config_bit;
      logic trigger_select_bit;
   } ttpo_ctrl_t;

   // One queued buffer write
   typedef struct packed {
      logic wr_high;
      logic wr_low;
      logic [1:0] high;
      logic [3:0] low;
   } ttpo_entry_t;
endpackage : ttpo_pkg

// *** verilog/ttpo_top.sv ***
// Timed parallel output channel: AHB-Lite registers, write queue, trigger logic
`timescale 1ns/1ps
`default_nettype none

module ttpo_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } ttpo_fifo_state_t;

   ttpo_fifo_state_t s;
   ttpo_fifo_state_t next_s;
   logic push;
   logic pop;

   // Pointers wrap by overflow, so only powers of two are served
   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
   begin : g_bad_param
      $error("ttpo_fifo: DEPTH must be a power of two of at least 2");
   end

   assign in_ready = s.cnt != (AW+1)'(DEPTH);
   assign out_valid = s.cnt != '0;
   assign out_data = s.mem[s.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.mem[s.wr] = in_data;
         next_s.wr = s.wr + 1'b1;
      end
      if (pop)
      begin
         next_s.rd = s.rd + 1'b1;
      end
      if (push && !pop)
      begin
         next_s.cnt = s.cnt + 1'b1;
      end
      else if (pop && !push)
      begin
         next_s.cnt = s.cnt - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end
endmodule : ttpo_fifo

module ttpo_top import ttpo_pkg::*; #(
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [2:0] compare_match_trigger,
   output logic [5:0] chan_output_pins
);
   typedef struct packed {
      logic ap_valid;
      logic ap_write;
      logic [2:0] ap_idx;
      logic ap_mapped;
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
      ttpo_ctrl_t ctrl;
      logic [5:0] per_bit_mode_mask;
      logic [1:0] high_out_buffer;
      logic [3:0] low_out_buffer;
      logic [1:0] latch_hi;
      logic [3:0] latch_lo;
      logic pend_hi;
      logic pend_lo;
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] lvl;
      logic fire_hi;
      logic fire_lo;
      logic [5:0] pins;
   } ttpo_state_t;

   localparam ttpo_state_t ST_RESET = '{ctrl: CTRL_RESET, per_bit_mode_mask: MODE_RESET,
      high_out_buffer: HIGH_RESET, low_out_buffer: LOW_RESET, hreadyout: 1'b1, default: '0};

   ttpo_state_t s;
   ttpo_state_t next_s;
   ttpo_entry_t push_data;
   ttpo_entry_t head;
   logic push_valid;
   logic push_ready;
   logic head_valid;
   logic pop;
   logic [2:0] rise;
   logic [2:0] fall;
   logic [2:0] hit;
   logic is_buf;

   // Writes queue here so software can post a burst of buffer values ahead of triggers
   ttpo_fifo #(
      .WIDTH($bits(ttpo_entry_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(hclk),
      .rst_n(hresetn),
      .ce(ce),
      .in_valid(push_valid),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(head_valid),
      .out_ready(pop),
      .out_data(head)
   );

   assign is_buf = s.ap_idx == IDX_LOW_BUF || s.ap_idx == IDX_HIGH_BUF;

   // A half that is still waiting for its trigger blocks newer values for that half
   assign pop = head_valid && (!s.ctrl.chan_output_enable
      || !((head.wr_high && s.pend_hi) || (head.wr_low && s.pend_lo)));

   always_comb
   begin
      next_s = s;
      push_valid = 1'b0;
      push_data = '0;
      // A level counts once the second and third stages agree
      next_s.s1 = compare_match_trigger;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      for (int i = 0; i < 3; i++)
      begin
         if (s.s2[i] == s.s3[i])
         begin
            next_s.lvl[i] = s.s2[i];
         end
      end
      rise = next_s.lvl & ~s.lvl;
      fall = ~next_s.lvl & s.lvl;
      hit = s.ctrl.trigger_edge_select ? rise : fall;
      if (s.ctrl.six_bit_config_bit)
      begin
         next_s.fire_hi = s.ctrl.trigger_select_bit ? hit[0] : hit[1];
         next_s.fire_lo = next_s.fire_hi;
      end
      else
      begin
         next_s.fire_hi = s.ctrl.trigger_select_bit ? hit[1] : hit[2];
         next_s.fire_lo = s.ctrl.trigger_select_bit ? hit[0] : hit[1];
      end

      // Transfer on the cycle after the edge was registered
      if (s.ctrl.chan_output_enable && s.fire_hi)
      begin
         next_s.latch_hi = s.high_out_buffer;
         next_s.pend_hi = 1'b0;
      end
      if (s.ctrl.chan_output_enable && s.fire_lo)
      begin
         next_s.latch_lo = s.low_out_buffer;
         next_s.pend_lo = 1'b0;
      end

      if (pop && head.wr_high)
      begin
         next_s.high_out_buffer = head.high;
         if (!s.ctrl.chan_output_enable)
         begin
            // Nothing waits for a trigger while disabled, so a stale mark must not block later writes
            next_s.latch_hi = head.high;
            next_s.pend_hi = 1'b0;
         end
         else
         begin
            next_s.pend_hi = 1'b1;
         end
      end
      if (pop && head.wr_low)
      begin
         next_s.low_out_buffer = head.low;
         if (!s.ctrl.chan_output_enable)
         begin
            next_s.latch_lo = head.low;
            next_s.pend_lo = 1'b0;
         end
         else
         begin
            next_s.pend_lo = 1'b1;
         end
      end

      // Data phase: one wait state, longer while the queue is full
      if (s.ap_valid)
      begin
         next_s.hreadyout = 1'b1;
         next_s.ap_valid = 1'b0;
         if (s.ap_write && s.ap_mapped)
         begin
            if (is_buf)
            begin
               push_valid = 1'b1;
               push_data.wr_high = s.ctrl.six_bit_config_bit || s.ap_idx == IDX_HIGH_BUF;
               push_data.wr_low = s.ctrl.six_bit_config_bit || s.ap_idx == IDX_LOW_BUF;
               push_data.high = hwdata[HIGH_POS +: 2];
               push_data.low = hwdata[3:0];
               if (!push_ready)
               begin
                  next_s.hreadyout = 1'b0;
                  next_s.ap_valid = 1'b1;
               end
            end
            else if (s.ap_idx == IDX_MODE)
            begin
               next_s.per_bit_mode_mask = hwdata[5:0];
            end
            else if (s.ap_idx == IDX_CTRL)
            begin
               next_s.ctrl = hwdata[CTRL_FIELD_POS +: 4];
            end
         end
         else if (!s.ap_write)
         begin
            next_s.hrdata = '0;
            if (!s.ap_mapped)
            begin
               next_s.hrdata = '0;
            end
            else if (is_buf)
            begin
               next_s.hrdata[5:0] = {s.high_out_buffer, s.low_out_buffer};
            end
            else if (s.ap_idx == IDX_MODE)
            begin
               next_s.hrdata[5:0] = s.per_bit_mode_mask;
            end
            else if (s.ap_idx == IDX_CTRL)
            begin
               next_s.hrdata[CTRL_FIELD_POS +: 4] = s.ctrl;
            end
            else
            begin
               next_s.hrdata[7:0] = {s.pend_hi, s.pend_lo, s.latch_hi, s.latch_lo};
            end
         end
      end

      // Address phase
      if (hsel && htrans[1] && hready)
      begin
         next_s.ap_valid = 1'b1;
         next_s.hreadyout = 1'b0;
         next_s.ap_write = hwrite;
         next_s.ap_idx = haddr[IDX_LSB +: 3];
         next_s.ap_mapped = haddr[31:IDX_LSB+3] == '0 && haddr[IDX_LSB +: 3] <= IDX_STATUS;
      end

      if (next_s.ctrl.chan_output_enable)
      begin
         next_s.pins = {next_s.latch_hi, next_s.latch_lo} & next_s.per_bit_mode_mask;
      end
      else
      begin
         next_s.pins = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         s <= ST_RESET;
      end
      else if (ce)
      begin
         s <= next_s;
      end
   end

   assign hreadyout = s.hreadyout;
   assign hresp = s.hresp;
   assign hrdata = s.hrdata;
   assign chan_output_pins = s.pins;

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence seq_t1_rises;
      ce && !s.lvl[1] && s.s2[1] && s.s3[1];
   endsequence

   sequence seq_t0_falls;
      ce && s.lvl[0] && !s.s2[0] && !s.s3[0];
   endsequence

   a_fire_high_copy: assert property (ce && s.ctrl.chan_output_enable && s.fire_hi
      |=> s.latch_hi == $past(s.high_out_buffer))
      else $error("high latch missed its transfer");
   a_fire_low_copy: assert property (ce && s.ctrl.chan_output_enable && s.fire_lo
      |=> s.latch_lo == $past(s.low_out_buffer))
      else $error("low latch missed its transfer");
   a_pin_timed: assert property (s.ctrl.chan_output_enable
      |-> s.pins == ({s.latch_hi, s.latch_lo} & s.per_bit_mode_mask))
      else $error("timed pin does not follow its latch");
   a_pin_port_zero: assert property (s.ctrl.chan_output_enable
      |-> (s.pins & ~s.per_bit_mode_mask) == '0)
      else $error("port mode pin not at 0");
   a_off_all_zero: assert property (!s.ctrl.chan_output_enable |-> s.pins == '0)
      else $error("pins active while disabled");
   a_off_direct_load: assert property (ce && !s.ctrl.chan_output_enable && pop && head.wr_low
      |=> s.latch_lo == $past(head.low))
      else $error("disabled write did not reach latch");
   a_on_latch_hold: assert property (ce && s.ctrl.chan_output_enable && !s.fire_lo
      |=> $stable(s.latch_lo))
      else $error("low latch moved without trigger");
   a_six_t1_rise: assert property (seq_t1_rises and (s.ctrl.six_bit_config_bit
      && !s.ctrl.trigger_select_bit && s.ctrl.trigger_edge_select) |=> s.fire_hi && s.fire_lo ##1
      (!s.ctrl.chan_output_enable || s.latch_lo == $past(s.low_out_buffer)))
      else $error("six-bit t1 rising edge lost");
   a_split_t0_fall: assert property (seq_t0_falls and (!s.ctrl.six_bit_config_bit
      && s.ctrl.trigger_select_bit && !s.ctrl.trigger_edge_select) |=> s.fire_lo && !s.fire_hi)
      else $error("split t0 falling edge lost");
   a_six_write_both: assert property (push_valid && s.ctrl.six_bit_config_bit
      |-> push_data.wr_high && push_data.wr_low)
      else $error("six-bit write missed a half");
   a_sync_agree: assert property (ce && s.s2 != s.s3 |=> s.lvl[0] == $past(s.lvl[0])
      || $past(s.s2[0] == s.s3[0]))
      else $error("trigger level moved before stages agreed");
endmodule : ttpo_top

`default_nettype wire

// *** test/ttpo_load.sv ***
// Parallel load model that latches the six channel pins each cycle
`timescale 1ns/1ps
`default_nettype none

module ttpo_load (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [5:0] pins,
   output logic [5:0] seen
);
   // Odd reset pattern so a stale capture never passes for a driven 0
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         seen <= 6'h2a;
      else
         seen <= pins;
endmodule : ttpo_load

`default_nettype wire

// *** test/timer_triggered_parallel_output_tb.sv ***
// Self-checking bench for the timed parallel output channel
`timescale 1ns/1ps
`default_nettype none

module timer_triggered_parallel_output_tb import ttpo_pkg::*; ;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] trig = 3'h0;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [5:0] pins;
   wire logic [5:0] seen;
   int n_tests = 0;
   int n_mismatch = 0;
   logic [31:0] expq[$];
   logic dp = 1'b0;
   logic dpr = 1'b0;
   logic fired = 1'b0;

   always #4 hclk = ~hclk;

   ttpo_top #(.FIFO_DEPTH(8)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .compare_match_trigger(trig), .chan_output_pins(pins));
   ttpo_load i_load (.hclk(hclk), .hresetn(hresetn), .pins(pins), .seen(seen));

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask : done

   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask : idle

   // Stalled queue writes may hold the bus for many cycles, hence the wide bound
   task automatic wait_rdy;
      int k;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 200);
      if (hreadyout !== 1'b1)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   endtask : wait_rdy

   task automatic xfer(input logic w, input logic [2:0] idx, input logic [31:0] d);
      htrans <= 2'h2;
      haddr <= {27'h0, idx, 2'h0};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask : xfer

   task automatic rd(input logic [2:0] idx, input logic [31:0] e);
      expq.push_back(e);
      xfer(1'b0, idx, 32'h0);
   endtask : rd

   task automatic wctl(input logic [3:0] c);
      xfer(1'b1, IDX_CTRL, {24'h0, c, 4'h0});
   endtask : wctl

   task automatic pchk(input logic [5:0] e);
      chk("pins", {26'h0, seen}, {26'h0, e});
   endtask : pchk

   always @(posedge hclk)
   begin
      if (dp && hreadyout === 1'b1)
      begin
         if (dpr)
            chk("hrdata", hrdata, expq.pop_front());
         chk("hresp", {31'h0, hresp}, 32'h0);
         dp = 1'b0;
      end
      if (hsel && htrans[1] && hreadyout === 1'b1)
      begin
         dp = 1'b1;
         dpr = !hwrite;
      end
   end

   initial
   begin
      logic [5:0] a, b, m, lat;
      logic eg, six, sel;
      int hs, ls;
      a = 6'($urandom(82));
      idle(4);
      hresetn <= 1'b1;
      // The load shows a pin value one edge after the block drives it
      idle(2);
      pchk(6'h00);
      rd(IDX_LOW_BUF, 32'h0);
      rd(IDX_MODE, 32'h0);
      rd(IDX_CTRL, 32'h0);
      rd(IDX_STATUS, 32'h0);
      xfer(1'b1, 3'h5, 32'hffffffff);
      rd(3'h5, 32'h0);
      done("reset");
      xfer(1'b1, IDX_LOW_BUF, 32'h3f);
      xfer(1'b1, IDX_HIGH_BUF, 32'h25);
      idle(2);
      rd(IDX_HIGH_BUF, 32'h2f);
      wctl(4'h2);
      xfer(1'b1, IDX_HIGH_BUF, 32'h15);
      idle(2);
      rd(IDX_LOW_BUF, 32'h15);
      rd(IDX_STATUS, 32'h15);
      xfer(1'b1, IDX_MODE, 32'h3f);
      idle(3);
      pchk(6'h00);
      done("buffers");
      // Every edge, configuration and select combination, triggers one at a time
      for (int c = 0; c < 8; c++)
      begin
         {eg, six, sel} = 3'(c);
         a = 6'($urandom);
         b = 6'($urandom);
         m = 6'($urandom);
         wctl({1'b0, eg, six, sel});
         trig <= {3{~eg}};
         xfer(1'b1, IDX_MODE, {26'h0, m});
         xfer(1'b1, IDX_LOW_BUF, {26'h0, a});
         xfer(1'b1, IDX_HIGH_BUF, {26'h0, a});
         idle(8);
         wctl({1'b1, eg, six, sel});
         idle(3);
         pchk(a & m);
         xfer(1'b1, IDX_LOW_BUF, {26'h0, b});
         if (!six)
            xfer(1'b1, IDX_HIGH_BUF, {26'h0, b});
         idle(8);
         pchk(a & m);
         lat = a;
         ls = sel ? 0 : 1;
         hs = six ? ls : (sel ? 1 : 2);
         for (int t = 0; t < 3; t++)
         begin
            trig[t] <= eg;
            idle(9);
            if (t == hs)
               lat[5:4] = b[5:4];
            if (t == ls)
               lat[3:0] = b[3:0];
            pchk(lat & m);
            trig[t] <= ~eg;
            idle(9);
         end
         rd(IDX_STATUS, {26'h0, lat});
         // Disable first with the old settings, so the next setup never changes a live channel
         wctl({1'b0, eg, six, sel});
         idle(3);
         pchk(6'h00);
      end
      wctl(4'h0);
      idle(3);
      pchk(6'h00);
      done("triggers");
      // Ten enabled writes to one half overflow the queue until triggers drain it
      wctl(4'h4);
      trig <= 3'h0;
      xfer(1'b1, IDX_MODE, 32'h3f);
      xfer(1'b1, IDX_LOW_BUF, 32'h0);
      xfer(1'b1, IDX_HIGH_BUF, 32'h0);
      idle(8);
      wctl(4'hc);
      fork
         begin
            for (int i = 1; i <= 10; i++)
               xfer(1'b1, IDX_LOW_BUF, 32'(i));
            chk("stall", {31'h0, fired}, 32'h1);
         end
         begin
            idle(40);
            repeat (10)
            begin
               trig[1] <= 1'b1;
               fired <= 1'b1;
               idle(9);
               trig[1] <= 1'b0;
               idle(9);
            end
         end
      join
      idle(3);
      pchk(6'h0a);
      rd(IDX_STATUS, 32'h0a);
      done("queue");
      // A trigger pulse that comes and goes while the clock enable is low is never seen
      xfer(1'b1, IDX_LOW_BUF, 32'h5);
      idle(2);
      ce <= 1'b0;
      trig[1] <= 1'b1;
      idle(9);
      trig[1] <= 1'b0;
      idle(3);
      ce <= 1'b1;
      idle(9);
      pchk(6'h0a);
      trig[1] <= 1'b1;
      idle(9);
      pchk(6'h05);
      trig[1] <= 1'b0;
      idle(9);
      done("clock enable");
      tally_and_finish();
   end
endmodule : timer_triggered_parallel_output_tb

`default_nettype wire
